// ===== qsf_ctrl.sv
// Purpose: Quad serial flash read controller, serial link controller end
// Assumes: Control inputs come from logic on clock; d_i comes from pins
// Notes: Word lengths not a multiple of the lane count round up to the next lane step
// Overview of operation
// - The block is always the link controller and drives serial clock and chip select itself.
// - Read data is taken on one, two or four data lines as configured.
// - A single memory-mapped request fetches a word from the flash without software sequencing.
// - Each word is programmable from 1 to 128 bits.
// - Each frame is programmable from 1 to 4096 words.
// - Word-done and frame-done events each raise their own enableable interrupt.
// - Between chip select going active and the first data, 0 to 3 serial clocks are inserted.
// - Three-pin, four-pin and six-pin (clock, select, four two-way data) wirings are supported.
// - Transfers use clock mode 0 and the flash launches read data to suit it.
// - Read data is sampled on the falling serial clock edge.
// - Outgoing data on the first data line changes only after a falling edge.
module qsf_ctrl
  import qsf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Software frame control
  input wire logic start,
  input wire logic [CMD_W-1:0] cmd_data,
  input wire logic [CMDLEN_W-1:0] cmd_len,
  input wire logic [1:0] width_sel,
  input wire logic [1:0] pin_mode,
  input wire logic [LEN_W-1:0] word_len_m1,
  input wire logic [CNT_W-1:0] word_cnt_m1,
  input wire logic [DLY_W-1:0] cs_delay,
  input wire logic [DIV_W-1:0] clk_div,
  input wire logic word_irq_en,
  input wire logic frame_irq_en,
  // Memory-mapped read
  input wire logic mm_req,
  input wire logic [MM_ADDR_W-1:0] mm_addr,
  input wire logic [OPC_W-1:0] mm_opcode,
  // Status
  output logic busy,
  output logic word_irq,
  output logic frame_irq,
  // Read data stream
  output logic rd_valid,
  output logic [WORD_W-1:0] rd_data,
  input wire logic rd_ready,
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic [LANES-1:0] d_o,
  output logic [LANES-1:0] d_oe,
  input wire logic [LANES-1:0] d_i
);
  logic rst_m_q, rst_n_q;
  logic [LANES-1:0] din_m_q, din_s_q;
  qsf_state_t st_q;
  logic [8:0] half_q, div_cnt_q;
  logic tick;
  logic [2:0] dly_q;
  logic [CMD_W-1:0] cmd_q;
  logic [CMDLEN_W-1:0] clen_q, cbit_q;
  qsf_width_t width_q;
  qsf_pins_t pins_q;
  logic [LEN_W-1:0] len_q;
  logic [CNT_W-1:0] cnt_q, wcnt_q;
  logic [7:0] bit_q;
  logic [7:0] bit_sum;
  logic [2:0] ln;
  logic [WORD_W-1:0] shr_q;
  logic sclk_q, cs_n_q, busy_q, word_irq_q, frame_irq_q;
  logic [LANES-1:0] d_o_q, d_oe_q;
  logic out_valid_q;
  logic [WORD_W-1:0] out_data_q;
  logic go, fall, sdin;
  qsf_width_t eff_w;

  qsf_fifo_if #(.W(WORD_W)) fi ();

  qsf_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clock),
    .rst_n(rst_n_q),
    .f(fi.fifo_side)
  );

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // Pin inputs pass two flops before use
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      din_m_q <= d_i;
      din_s_q <= din_m_q;
    end
  end

  // Dual and quad need all six pins; otherwise fall back to one line
  assign eff_w = (qsf_pins_t'(pin_mode) == QSF_PIN6) ? qsf_width_t'(width_sel)
                 : QSF_W_SINGLE;
  assign go = (st_q == QSF_ST_IDLE) && (start || mm_req);
  assign ln = qsf_lanes(width_q);
  assign bit_sum = bit_q + {5'h00, ln};
  assign fall = tick && sclk_q;
  // Three-pin wiring reads back on the shared first line
  assign sdin = (pins_q == QSF_PIN3) ? din_s_q[0] : din_s_q[1];

  // Serial clock divider; paused while idle or stalled so sclk stays low
  assign tick = (st_q != QSF_ST_IDLE) && (st_q != QSF_ST_HOLD) && (div_cnt_q == half_q - HALF_ONE);
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      half_q <= MIN_HALF;
      div_cnt_q <= '0;
    end else begin
      if (go) begin
        half_q <= ({1'b0, clk_div} + HALF_ONE < MIN_HALF) ? MIN_HALF
                  : {1'b0, clk_div} + HALF_ONE;
      end
      if (tick || st_q == QSF_ST_IDLE || st_q == QSF_ST_HOLD) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + HALF_ONE;
      end
    end
  end

  // Frame sequencer and link pins
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= QSF_ST_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      d_o_q <= '0;
      d_oe_q <= '0;
      busy_q <= 1'b0;
      dly_q <= '0;
      cmd_q <= '0;
      clen_q <= '0;
      cbit_q <= '0;
      width_q <= QSF_W_SINGLE;
      pins_q <= QSF_PIN6;
      len_q <= '0;
      cnt_q <= '0;
      wcnt_q <= '0;
      bit_q <= '0;
    end else begin
      unique case (st_q)
        QSF_ST_IDLE: begin
          sclk_q <= 1'b0;
          if (go) begin
            cs_n_q <= 1'b0;
            busy_q <= 1'b1;
            width_q <= eff_w;
            pins_q <= qsf_pins_t'(pin_mode);
            dly_q <= {cs_delay, 1'b0};
            cbit_q <= '0;
            wcnt_q <= '0;
            bit_q <= '0;
            if (start) begin
              cmd_q <= cmd_data;
              clen_q <= cmd_len;
              len_q <= word_len_m1;
              cnt_q <= word_cnt_m1;
            end else begin
              cmd_q <= {mm_opcode, mm_addr};
              clen_q <= MM_CMD_LEN;
              len_q <= MM_WORD_LEN_M1;
              cnt_q <= MM_WORD_CNT_M1;
            end
            st_q <= QSF_ST_LEAD;
          end
        end
        QSF_ST_LEAD: begin
          // Two ticks per inserted serial clock; zero delay leaves at once
          if (dly_q == '0 || (tick && dly_q == 3'h1)) begin
            if (clen_q != '0) begin
              d_o_q[0] <= cmd_q[CMD_W-1];
              d_oe_q[0] <= 1'b1;
              st_q <= QSF_ST_CMD;
            end else begin
              st_q <= QSF_ST_DATA;
            end
          end else if (tick) begin
            dly_q <= dly_q - 3'h1;
          end
        end
        QSF_ST_CMD: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (fall) begin
            sclk_q <= 1'b0;
            cmd_q <= {cmd_q[CMD_W-2:0], 1'b0};
            cbit_q <= cbit_q + 6'h01;
            if (cbit_q == clen_q - 6'h01) begin
              d_oe_q[0] <= 1'b0;
              st_q <= QSF_ST_DATA;
            end else begin
              d_o_q[0] <= cmd_q[CMD_W-2];
            end
          end
        end
        QSF_ST_DATA: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (fall) begin
            sclk_q <= 1'b0;
            bit_q <= bit_sum;
            if (bit_sum > {1'b0, len_q}) begin
              st_q <= QSF_ST_HOLD;
            end
          end
        end
        QSF_ST_HOLD: begin
          // Full FIFO holds the link here with sclk low
          if (fi.in_ready) begin
            bit_q <= '0;
            wcnt_q <= wcnt_q + 12'h001;
            st_q <= (wcnt_q == cnt_q) ? QSF_ST_TAIL : QSF_ST_DATA;
          end
        end
        QSF_ST_TAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            d_oe_q <= '0;
            busy_q <= 1'b0;
            st_q <= QSF_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive shifter; newest bits enter at the low end, line 3 is the top bit of a nibble
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shr_q <= '0;
    end else if (go) begin
      shr_q <= '0;
    end else if (fall && st_q == QSF_ST_DATA) begin
      unique case (width_q)
        QSF_W_DUAL: shr_q <= {shr_q[WORD_W-3:0], din_s_q[1:0]};
        QSF_W_QUAD: shr_q <= {shr_q[WORD_W-5:0], din_s_q};
        default: shr_q <= {shr_q[WORD_W-2:0], sdin};
      endcase
    end else if (st_q == QSF_ST_HOLD && fi.in_ready) begin
      shr_q <= '0;
    end
  end

  assign fi.in_valid = (st_q == QSF_ST_HOLD);
  assign fi.in_data = shr_q;
  assign fi.out_ready = !out_valid_q || rd_ready;

  // Event pulses and registered output stage
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word_irq_q <= 1'b0;
      frame_irq_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      word_irq_q <= word_irq_en && st_q == QSF_ST_HOLD && fi.in_ready;
      frame_irq_q <= frame_irq_en && st_q == QSF_ST_TAIL && tick;
      if (fi.out_ready) begin
        out_valid_q <= fi.out_valid;
        if (fi.out_valid) begin
          out_data_q <= fi.out_data;
        end
      end
    end
  end

  assign busy = busy_q;
  assign word_irq = word_irq_q;
  assign frame_irq = frame_irq_q;
  assign rd_valid = out_valid_q;
  assign rd_data = out_data_q;
  assign sclk = sclk_q;
  assign cs_n = cs_n_q;
  assign d_o = d_o_q;
  assign d_oe = d_oe_q;
endmodule

// ===== qsf_ctrl_monitor.sv
// Purpose: Port checker for qsf_ctrl
// Assumes: The divider never gives a half period under 3 cycles
// Notes: Bound at the foot of this file
module qsf_ctrl_monitor
  import qsf_pkg::*;
(
  // Clock, reset and controls
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic mm_req,
  input wire logic word_irq_en,
  input wire logic frame_irq_en,
  input wire logic rd_ready,
  // Outputs watched
  input wire logic busy,
  input wire logic word_irq,
  input wire logic frame_irq,
  input wire logic rd_valid,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [LANES-1:0] d_o,
  input wire logic [LANES-1:0] d_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk high while idle");
  AST_TAKE: assert property ((start || mm_req) && !busy |=> !cs_n && busy)
    else $error("request not taken");
  AST_D0_FALL: assert property (d_oe[0] && $past(d_oe[0]) && $changed(d_o[0])
    |-> $fell(sclk)) else $error("d0 moved off a fall");
  AST_NO_TARGET: assert property (cs_n |-> d_oe == 4'h0)
    else $error("driving while idle");
  AST_LANES_IN: assert property (d_oe[3:1] == 3'h0)
    else $error("read lane driven");
  AST_CS_RISE: assert property ($rose(cs_n) |-> !busy && !sclk)
    else $error("frame end untidy");
  AST_LEAD_LOW: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("lead too short");
  AST_HIGH_MIN: assert property ($rose(sclk) |-> sclk [*3])
    else $error("sclk high too short");
  AST_LOW_MIN: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("sclk low too short");
  AST_FRAME_IRQ: assert property ($rose(cs_n) && frame_irq_en |-> frame_irq)
    else $error("frame irq missing");
  AST_WORD_IRQ_OFF: assert property (!word_irq_en && !$past(word_irq_en) |-> !word_irq)
    else $error("word irq while off");
  AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("word dropped");
  cover property (frame_irq);
  cover property (word_irq);
  cover property (rd_valid && !rd_ready);
endmodule

bind qsf_ctrl qsf_ctrl_monitor mon_u (.clock, .rst_b, .start, .mm_req, .word_irq_en,
  .frame_irq_en, .rd_ready, .busy, .word_irq, .frame_irq, .rd_valid, .rd_data, .sclk,
  .cs_n, .d_o, .d_oe);

// ===== qsf_ctrl_test.sv
// Purpose: Self-checking bench for qsf_ctrl with a flash model
// Assumes: Model launches read bits on the rising serial clock
// Notes: One row runs the full 4096-word frame
module qsf_ctrl_test
  import qsf_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [1:0] w;
    logic [1:0] pm;
    logic [LEN_W-1:0] len;
    logic [CNT_W-1:0] cnt;
    logic [DLY_W-1:0] dly;
    logic [DIV_W-1:0] div;
    logic [CMDLEN_W-1:0] cl;
    logic ien;
  } qsf_row_t;
  localparam logic [127:0] PAT = 128'hC3A5_0F96_1E2D_4B78_E01D_9AB3_5C6E_7D18;
  localparam logic [CMD_W-1:0] CMD = 32'hA55A_3CC3;
  qsf_row_t rows [9] = '{
    '{2'h0, 2'h0, 7'h07, 12'h001, 2'h0, 8'h02, 6'h08, 1'b1},
    '{2'h0, 2'h1, 7'h00, 12'h002, 2'h1, 8'h02, 6'h04, 1'b1},
    '{2'h1, 2'h2, 7'h0F, 12'h001, 2'h2, 8'h05, 6'h08, 1'b0},
    '{2'h2, 2'h2, 7'h7F, 12'h000, 2'h3, 8'h02, 6'h08, 1'b1},
    '{2'h2, 2'h2, 7'h04, 12'h002, 2'h0, 8'h00, 6'h20, 1'b1},
    '{2'h3, 2'h2, 7'h0B, 12'h001, 2'h1, 8'h03, 6'h01, 1'b0},
    '{2'h1, 2'h0, 7'h09, 12'h001, 2'h0, 8'h02, 6'h08, 1'b1},
    '{2'h0, 2'h0, 7'h00, 12'hFFF, 2'h0, 8'h00, 6'h08, 1'b1},
    '{2'h2, 2'h2, 7'h0F, 12'h001, 2'h1, 8'h02, 6'h00, 1'b1}
  };
  qsf_row_t cfg = '0;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic mm_req = 1'b0;
  logic rd_ready = 1'b1;
  logic [MM_ADDR_W-1:0] mm_addr = 24'h3C_A5F1;
  logic [OPC_W-1:0] mm_opcode = 8'h5E;
  logic [2:0] lanes = 3'h1;
  logic sel_d1 = 1'b0;
  logic busy, word_irq, frame_irq, rd_valid, sclk, cs_n;
  logic [WORD_W-1:0] rd_data;
  logic [LANES-1:0] d_o, d_oe, d_drv, d_line;
  logic [CMD_W-1:0] cmd_got;
  logic [WORD_W-1:0] got [$];
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int wirq = 0;
  int firq = 0;
  // Each lane carries whichever side enables it
  assign d_line = (d_oe & d_o) | (~d_oe & d_drv);
  qsf_ctrl dut_u (.clock, .rst_b, .start, .cmd_data(CMD), .cmd_len(cfg.cl), .width_sel(cfg.w),
    .pin_mode(cfg.pm), .word_len_m1(cfg.len), .word_cnt_m1(cfg.cnt), .cs_delay(cfg.dly),
    .clk_div(cfg.div), .word_irq_en(cfg.ien), .frame_irq_en(cfg.ien), .mm_req, .mm_addr,
    .mm_opcode, .busy, .word_irq, .frame_irq, .rd_valid, .rd_data, .rd_ready, .sclk, .cs_n,
    .d_o, .d_oe, .d_i(d_line));
  qsf_flash_model #(.PAT(PAT)) flash_u (.sclk, .cs_n, .d_line, .d_drv, .cmd_len(cfg.cl),
    .lanes, .sel_d1, .cmd_got);
  always #2.5 clock = ~clock;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [WORD_W-1:0] exp_word(input int off, input int bits);
    exp_word = '0;
    for (int i = 0; i < bits; i++) exp_word = {exp_word[WORD_W-2:0], PAT[127 - ((off + i) % 128)]};
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1 && rd_ready) got.push_back(rd_data);
    if (word_irq === 1'b1) wirq++;
    if (frame_irq === 1'b1) firq++;
    // Longest frame needs about 29000 cycles
    if (cyc == 80000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic run_frame(input qsf_row_t r, input logic mm, input logic [CMD_W-1:0] ecmd);
    int n;
    int h;
    int bits;
    int lead;
    n = (r.pm != 2'h2) ? 1 : (r.w == 2'h1) ? 2 : (r.w == 2'h2) ? 4 : 1;
    h = (r.div < 8'h2) ? 3 : r.div + 1;
    bits = ((r.len + n) / n) * n;
    lead = 0;
    @(posedge clock);
    got.delete();
    wirq = 0;
    firq = 0;
    cfg <= r;
    lanes <= 3'(n);
    // Only the three-pin wiring reads back on line 0
    sel_d1 <= (r.pm != 2'h0);
    if (mm) mm_req <= 1'b1;
    else start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    mm_req <= 1'b0;
    do begin
      @(posedge clock);
      #1;
      lead++;
    end while (sclk !== 1'b1 && lead < 2000);
    while (busy !== 1'b0) @(posedge clock);
    repeat (40) @(posedge clock);
    #1;
    check("lead", r.dly * 2 * h + h, lead);
    check("command", ecmd, cmd_got);
    check("words", r.cnt + 1, got.size());
    foreach (got[k]) check("word", exp_word(k * bits, bits), got[k]);
    check("word irqs", r.ien ? r.cnt + 1 : 0, wirq);
    check("frame irqs", r.ien, firq);
    $display("frame of %0d words done", got.size());
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    foreach (rows[i]) run_frame(rows[i], 1'b0, CMD >> (CMD_W - rows[i].cl));
    // Fill the FIFO until the link stalls, then drain it
    rd_ready <= 1'b0;
    fork
      run_frame('{2'h0, 2'h0, 7'h07, 12'h013, 2'h0, 8'h00, 6'h08, 1'b1}, 1'b0, CMD >> 24);
      begin
        repeat (1500) @(posedge clock);
        #1;
        check("stall cs_n", 0, cs_n);
        check("stall sclk", 0, sclk);
        check("stall valid", 1, rd_valid);
        @(posedge clock);
        rd_ready <= 1'b1;
      end
    join
    @(posedge clock);
    cfg <= rows[2];
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (60) @(posedge clock);
    rst_b <= 1'b0;
    #1;
    check("reset cs_n", 1, cs_n);
    check("reset sclk", 0, sclk);
    check("reset oe", 0, d_oe);
    check("reset busy", 0, busy);
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    $display("mid-frame reset done");
    // A start landing mid-frame must be ignored
    fork
      run_frame('{2'h0, 2'h0, 7'h1F, 12'h000, 2'h0, 8'h02, 6'h20, 1'b1}, 1'b1,
        {mm_opcode, mm_addr});
      begin
        repeat (30) @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
      end
    join
    wrap_up();
  end
endmodule

// ===== qsf_fifo.sv
// Purpose: Flip-flop FIFO for received words
// Assumes: Depth is a power of two
// Notes: Full drops in_ready, which stalls the serial clock upstream
module qsf_fifo #(
  parameter int W = 128,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Carrier
  qsf_fifo_if.fifo_side f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign f.in_ready = (cnt_q != FULL_CNT);
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data = mem_q[rptr_q];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= f.in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + PTR_ONE;
      end
      if (pop) begin
        rptr_q <= rptr_q + PTR_ONE;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + CNT_ONE;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - CNT_ONE;
      end
    end
  end
endmodule

// ===== qsf_fifo_if.sv
// Purpose: Valid/ready carrier between the controller core and its read-data FIFO
// Assumes: Both ends on the functional clock
// Notes: Width is a parameter so the FIFO can be reused
interface qsf_fifo_if #(parameter int W = 128);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo_side (input in_valid, input in_data, output in_ready,
                     output out_valid, output out_data, input out_ready);
  modport user_side (output in_valid, output in_data, input in_ready,
                     input out_valid, input out_data, output out_ready);
endinterface

// ===== qsf_flash_model.sv
// Purpose: Behavioural quad serial flash for the bench
// Assumes: Mode 0, read bits launched on the rising serial clock
// Notes: A released line shows the inverse of its last level, never a held bit
module qsf_flash_model
  import qsf_pkg::*;
#(
  parameter logic [127:0] PAT = 128'h0
) (
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [LANES-1:0] d_line,
  output logic [LANES-1:0] d_drv,
  // Frame setup
  input wire logic [CMDLEN_W-1:0] cmd_len,
  input wire logic [2:0] lanes,
  input wire logic sel_d1,
  output logic [CMD_W-1:0] cmd_got
);
  timeunit 1ns;
  timeprecision 100ps;
  int rises = 0;
  int idx = 0;
  logic [3:0] nx;
  initial d_drv = 4'h5;
  always @(posedge cs_n) d_drv <= ~d_drv;
  always @(negedge cs_n) begin
    rises = 0;
    idx = 0;
    cmd_got = '0;
  end
  // Launch on the rise so the controller's falling-edge sample sees a settled bit
  always @(posedge sclk) begin
    for (int j = 0; j < 4; j++) nx[3 - j] = PAT[127 - ((idx + j) % 128)];
    if (rises < cmd_len) cmd_got <= {cmd_got[CMD_W-2:0], d_line[0]};
    else if (lanes == 3'h4) d_drv <= nx;
    else if (lanes == 3'h2) d_drv <= {~d_drv[3:2], nx[3:2]};
    else if (sel_d1) d_drv <= {~d_drv[3:2], nx[3], ~d_drv[0]};
    else d_drv <= {~d_drv[3:1], nx[3]};
    if (rises >= cmd_len) idx = idx + lanes;
    rises = rises + 1;
  end
endmodule

// ===== qsf_pkg.sv
// Purpose: Shared constants, encodings and types for the quad serial flash controller
// Assumes: 200 MHz functional clock
// Notes: Serial clock half period is clamped so the link never runs faster than its minimum cycle
package qsf_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_MIN_PERIOD_NS = 25;
  localparam int MIN_HALF_CYC =
    (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam logic [8:0] MIN_HALF = 9'(MIN_HALF_CYC);
  localparam logic [8:0] HALF_ONE = 9'h001;

  localparam int DIV_W = 8;
  localparam int WORD_W = 128;
  localparam int LEN_W = 7;
  localparam int CNT_W = 12;
  localparam int CMD_W = 32;
  localparam int CMDLEN_W = 6;
  localparam int DLY_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int MM_ADDR_W = 24;
  localparam int OPC_W = 8;
  localparam int LANES = 4;

  localparam logic [LEN_W-1:0] MM_WORD_LEN_M1 = 7'h1F;
  localparam logic [CNT_W-1:0] MM_WORD_CNT_M1 = 12'h000;
  localparam logic [CMDLEN_W-1:0] MM_CMD_LEN = 6'h20;

  typedef enum logic [1:0] {
    QSF_W_SINGLE = 2'h0,
    QSF_W_DUAL = 2'h1,
    QSF_W_QUAD = 2'h2
  } qsf_width_t;

  typedef enum logic [1:0] {
    QSF_PIN3 = 2'h0,
    QSF_PIN4 = 2'h1,
    QSF_PIN6 = 2'h2
  } qsf_pins_t;

  typedef enum logic [5:0] {
    QSF_ST_IDLE = 6'h01,
    QSF_ST_LEAD = 6'h02,
    QSF_ST_CMD = 6'h04,
    QSF_ST_DATA = 6'h08,
    QSF_ST_HOLD = 6'h10,
    QSF_ST_TAIL = 6'h20
  } qsf_state_t;

  // Data lines advanced per falling edge
  function automatic logic [2:0] qsf_lanes(input qsf_width_t w);
    case (w)
      QSF_W_DUAL: qsf_lanes = 3'h2;
      QSF_W_QUAD: qsf_lanes = 3'h4;
      default: qsf_lanes = 3'h1;
    endcase
  endfunction
endpackage
